// [design/rap_pkg.sv]
/*
 * package of the register access policy block: address map, option
 * classes, fixed values.
 * assumes byte-wide registers on a 16-bit address space.
 */
package rap_pkg;
	// ==========================================================
	// widths
	localparam int unsigned ADDR_W = 16;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned NREG   = 16;
	localparam int unsigned IDX_W  = 4;

	// ==========================================================
	// address map
	localparam logic [15:0] ADDR_LIVE_A  = 16'h0000;
	localparam logic [15:0] ADDR_LIVE_B  = 16'h0001;
	localparam logic [15:0] ADDR_XFER    = 16'h000f;
	localparam logic [15:0] ADDR_CFG_LO  = 16'h0100;
	localparam logic [15:0] ADDR_CFG_HI  = 16'h0108;
	localparam logic [15:0] ADDR_CFG_RSV = 16'h0107;
	localparam logic [15:0] ADDR_STAT    = 16'h0200;
	localparam logic [15:0] ADDR_STAT_LV = 16'h0201;

	// ==========================================================
	// transfer strobe
	localparam logic [7:0] XFER_CMD     = 8'h01;
	localparam int unsigned XFER_BIT    = 0;
	localparam logic [7:0] XFER_RSV_MSK = 8'hfe;

	// read-only identification, values arbitrary
	localparam logic [7:0] ID_CHIP_TYPE = 8'h0a;
	localparam logic [7:0] ID_REVISION  = 8'h01;

	localparam logic [7:0] BYTE_ZERO    = 8'h00;
	localparam logic [7:0] RST_VAL      = 8'h00;

	typedef enum logic [1:0] {
		RAP_CLS_NONE,
		RAP_CLS_REGULAR,
		RAP_CLS_LIVE,
		RAP_CLS_RO
	} rap_class_t;
endpackage : rap_pkg

// [design/rap_decode.sv]
/*
 * address decoder: class and storage index of a register address.
 * assumes a purely combinational lookup.
 */
`timescale 1ns/100ps
module rap_decode (
	input  wire logic [rap_pkg::ADDR_W-1:0] addr,
	output rap_pkg::rap_class_t             cls,
	output logic [rap_pkg::IDX_W-1:0]       idx,
	output logic                            is_xfer,
	output logic                            is_ro_id
);
	import rap_pkg::*;

	always_comb begin
		cls      = RAP_CLS_NONE;
		idx      = '0;
		is_xfer  = 1'b0;
		is_ro_id = 1'b0;
		if (addr == ADDR_LIVE_A || addr == ADDR_LIVE_B) begin
			cls = RAP_CLS_LIVE;
			idx = addr[IDX_W-1:0];
		end else if (addr == ADDR_XFER) begin
			cls     = RAP_CLS_LIVE;
			is_xfer = 1'b1;
		end else if (addr >= ADDR_CFG_LO && addr <= ADDR_CFG_HI &&
				addr != ADDR_CFG_RSV) begin
			cls = RAP_CLS_REGULAR;
			idx = addr[IDX_W-1:0] + 4'h2;
		end else if (addr == ADDR_STAT) begin
			cls      = RAP_CLS_RO;
			is_ro_id = 1'b1;
		end else if (addr == ADDR_STAT_LV) begin
			cls = RAP_CLS_RO;
		end
	end
endmodule : rap_decode

// [design/rap_regbank.sv]
/*
 * register access policy bank: buffered/active copies, transfer strobe,
 * live, read only and unmapped handling, plus an autoclear action bit.
 * assumes a host port giving one access per cycle, synchronous to mclk.
 */
`timescale 1ns/100ps
module rap_regbank (
	input  wire logic                       mclk,
	input  wire logic                       arst_n,
	input  wire logic                       clk_en,
	input  wire logic                       req,
	input  wire logic                       wr,
	input  wire logic                       src_serial,
	input  wire logic                       lock_regs,
	input  wire logic [rap_pkg::ADDR_W-1:0] addr,
	input  wire logic [rap_pkg::DATA_W-1:0] wdata,
	input  wire logic [rap_pkg::DATA_W-1:0] status_in,
	input  wire logic                       action_done,
	output logic [rap_pkg::DATA_W-1:0]      rdata,
	output logic                            rvalid,
	output logic                            denied,
	output logic                            xfer_pulse,
	output logic                            action_go,
	output logic [rap_pkg::NREG*rap_pkg::DATA_W-1:0] active_out
);
	import rap_pkg::*;

	// ==========================================================
	// decode and policy
	rap_class_t         cls;
	logic [IDX_W-1:0]   idx;
	logic               is_xfer;
	logic               is_ro_id;
	logic               grant;
	logic               wr_ok;
	logic               rd_ok;

	rap_decode u_dec (
		.addr     (addr),
		.cls      (cls),
		.idx      (idx),
		.is_xfer  (is_xfer),
		.is_ro_id (is_ro_id)
	);

	always_comb begin
		// each class adds restrictions; all must pass
		grant = (cls != RAP_CLS_NONE);
		if (cls == RAP_CLS_REGULAR && lock_regs)
			grant = 1'b0;
		if (cls == RAP_CLS_RO && wr)
			grant = 1'b0;
		if (cls == RAP_CLS_RO && !wr)
			grant = 1'b1;
		if (cls == RAP_CLS_LIVE && !src_serial && !is_xfer)
			grant = 1'b0;
		wr_ok = req && wr && grant;
		rd_ok = req && !wr && grant;
	end

	// ==========================================================
	// storage
	logic [DATA_W-1:0] buf_reg [NREG];
	logic [DATA_W-1:0] act_reg [NREG];
	logic              xfer_next;
	logic              pend_reg;
	logic              go_reg;
	logic [DATA_W-1:0] live_stat_reg;

	// reserved bits of the strobe byte are ignored
	assign xfer_next = wr_ok && is_xfer && wdata[XFER_BIT];

	genvar g;
	generate
		for (g = 0; g < NREG; g++) begin : g_reg
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					buf_reg[g] <= RST_VAL;
				end else if (clk_en && wr_ok && !is_xfer &&
						idx == IDX_W'(g)) begin
					buf_reg[g] <= wdata;
				end
			end
			always_ff @(posedge mclk or negedge arst_n) begin
				if (!arst_n) begin
					act_reg[g] <= RST_VAL;
				end else if (clk_en) begin
					if (wr_ok && !is_xfer && cls == RAP_CLS_LIVE &&
							idx == IDX_W'(g))
						act_reg[g] <= wdata;
					else if (xfer_next && g > 1)
						act_reg[g] <= buf_reg[g];
				end
			end
			assign active_out[g*DATA_W +: DATA_W] = act_reg[g];
		end
	endgenerate

	// ==========================================================
	// autoclear action: strobe bit requests, completion clears
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			pend_reg <= 1'b0;
		end else if (clk_en) begin
			if (xfer_next)
				pend_reg <= 1'b1;
			else if (action_done)
				pend_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			go_reg <= 1'b0;
		end else if (clk_en) begin
			go_reg <= xfer_next;
		end
	end

	assign xfer_pulse = go_reg;
	assign action_go  = pend_reg;

	// live read-only status follows input without the strobe
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			live_stat_reg <= RST_VAL;
		end else if (clk_en) begin
			live_stat_reg <= status_in;
		end
	end

	// ==========================================================
	// read path
	logic [DATA_W-1:0] rd_next;

	always_comb begin
		rd_next = BYTE_ZERO;
		if (rd_ok) begin
			if (is_xfer)
				rd_next = {7'h00, pend_reg};
			else if (is_ro_id)
				rd_next = ID_CHIP_TYPE;
			else if (cls == RAP_CLS_RO)
				rd_next = live_stat_reg;
			else
				rd_next = buf_reg[idx];
		end
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rdata  <= BYTE_ZERO;
			rvalid <= 1'b0;
			denied <= 1'b0;
		end else if (clk_en) begin
			rdata  <= rd_next;
			rvalid <= req && !wr;
			denied <= req && !grant;
		end
	end

	// ==========================================================
	// checks
	a_denied_read_zero: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && req && !wr && !grant |=> rdata == BYTE_ZERO)
		else $error("denied read not zero");
	a_unmapped_deny: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && req && cls == RAP_CLS_NONE |=> denied)
		else $error("unmapped access not denied");
	a_denied_write_keep: assert property (@(posedge mclk)
		disable iff (!arst_n)
		clk_en && req && wr && !grant && !xfer_next
		|=> $stable(active_out))
		else $error("denied write changed state");
	a_ro_read_ok: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && req && !wr && cls == RAP_CLS_RO |=> !denied)
		else $error("read only read denied");
	a_ro_write_drop: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && req && wr && cls == RAP_CLS_RO |=> denied)
		else $error("read only write accepted");
	a_lock_deny: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && req && cls == RAP_CLS_REGULAR && lock_regs
		|=> denied)
		else $error("locked regular access granted");
	a_xfer_pulse: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && xfer_next |=> xfer_pulse && action_go)
		else $error("transfer strobe not seen");
	a_auto_clear: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en && action_done && !xfer_next |=> !action_go)
		else $error("autoclear bit not cleared");
	a_live_stat: assert property (@(posedge mclk) disable iff (!arst_n)
		clk_en |=> live_stat_reg == $past(status_in))
		else $error("live status lagging");

	c_xfer: cover property (@(posedge mclk) disable iff (!arst_n)
		xfer_next);
	c_denied: cover property (@(posedge mclk) disable iff (!arst_n)
		req && !grant);
	c_live_wr: cover property (@(posedge mclk) disable iff (!arst_n)
		wr_ok && cls == RAP_CLS_LIVE && !is_xfer);
	c_done: cover property (@(posedge mclk) disable iff (!arst_n)
		pend_reg && action_done);
endmodule : rap_regbank

// [sim/rap_host.sv]
/*
 * serial host model: issues one register access per call.
 * assumes the access port of the register bank, sampled on rising mclk.
 */
`timescale 1ns/100ps
module rap_host (
	input  wire logic                       mclk,
	output logic                            req,
	output logic                            wr,
	output logic [rap_pkg::ADDR_W-1:0]      addr,
	output logic [rap_pkg::DATA_W-1:0]      wdata,
	input  wire logic [rap_pkg::DATA_W-1:0] rdata,
	input  wire logic                       denied
);
	import rap_pkg::*;
	initial begin
		req = 1'b0;
		wr = 1'b0;
		addr = 16'h0000;
		wdata = 8'h00;
	end
	// ==========================================================
	// access: answer taken at the edge after the request edge
	task automatic access(input logic w, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] rd, output logic dn);
		@(posedge mclk);
		#1;
		req = 1'b1;
		wr = w;
		addr = a;
		// reserved strobe bits always written as default
		wdata = (a == ADDR_XFER) ? (d & ~XFER_RSV_MSK) : d;
		@(posedge mclk);
		#1;
		rd = rdata;
		dn = denied;
		req = 1'b0;
		// released lines must not keep the old value
		addr = ~a;
		wdata = ~d;
	endtask : access
endmodule : rap_host

// [sim/register_access_policy_tb_top.sv]
/*
 * self-checking bench of the register access policy bank.
 * assumes rap_pkg and the rap_host model.
 */
`timescale 1ns/100ps
module register_access_policy_tb_top;
	import rap_pkg::*;
	logic                   mclk, arst_n, src_serial, lock_regs, action_done;
	logic                   req, wr, rvalid, denied, xfer_pulse, action_go;
	logic [ADDR_W-1:0]      addr;
	logic [DATA_W-1:0]      wdata, rdata, status_in, rd;
	logic [NREG*DATA_W-1:0] active_out;
	logic                   dn, clk_en;
	int                     n_mismatch = 0;
	int                     tests_run = 0;

	rap_regbank uut (.mclk(mclk), .arst_n(arst_n), .clk_en(clk_en),
		.req(req), .wr(wr), .src_serial(src_serial), .lock_regs(lock_regs),
		.addr(addr), .wdata(wdata), .status_in(status_in),
		.action_done(action_done), .rdata(rdata), .rvalid(rvalid),
		.denied(denied), .xfer_pulse(xfer_pulse), .action_go(action_go),
		.active_out(active_out));
	rap_host host (.mclk(mclk), .req(req), .wr(wr), .addr(addr),
		.wdata(wdata), .rdata(rdata), .denied(denied));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// ==========================================================
	// helpers
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic acc(input logic w, input logic [15:0] a,
		input logic [7:0] d);
		host.access(w, a, d, rd, dn);
	endtask : acc
	function automatic logic [7:0] act(input int i);
		return active_out[8*i +: 8];
	endfunction : act
	task automatic close_out;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out
	// ==========================================================
	// scenarios
	task automatic t_buffer;
		acc(1'b1, ADDR_CFG_LO, 8'h5a);
		chk(act(2), 8'h00);
		acc(1'b0, ADDR_CFG_LO, 8'h00);
		chk(rd, 8'h5a);
		chk(rvalid, 8'h01);
		acc(1'b1, ADDR_XFER, XFER_CMD);
		chk(xfer_pulse, 8'h01);
		chk(act(2), 8'h5a);
		chk(action_go, 8'h01);
		acc(1'b0, ADDR_XFER, 8'h00);
		chk(rd, 8'h01);
		@(posedge mclk);
		#1 action_done = 1'b1;
		@(posedge mclk);
		#1 action_done = 1'b0;
		chk(action_go, 8'h00);
		$display("test buffer done");
	endtask : t_buffer
	task automatic t_live;
		src_serial = 1'b1;
		acc(1'b1, ADDR_LIVE_A, 8'h3c);
		chk(act(0), 8'h3c);
		src_serial = 1'b0;
		acc(1'b1, ADDR_LIVE_B, 8'hc3);
		chk(dn, 8'h01);
		chk(act(1), 8'h00);
		acc(1'b0, ADDR_LIVE_A, 8'h00);
		chk(rd, 8'h00);
		$display("test live done");
	endtask : t_live
	task automatic t_deny;
		logic [15:0] bad[2];
		bad = '{ADDR_CFG_RSV, 16'h0300};
		lock_regs = 1'b1;
		acc(1'b1, ADDR_CFG_HI, 8'h77);
		chk(dn, 8'h01);
		lock_regs = 1'b0;
		acc(1'b0, ADDR_CFG_HI, 8'h00);
		chk(rd, 8'h00);
		foreach (bad[i]) begin
			acc(1'b1, bad[i], 8'h55);
			acc(1'b0, bad[i], 8'h00);
			chk(rd, 8'h00);
			chk(dn, 8'h01);
		end
		$display("test deny done");
	endtask : t_deny
	task automatic t_ro;
		lock_regs = 1'b1;
		acc(1'b0, ADDR_STAT, 8'h00);
		chk(rd, ID_CHIP_TYPE);
		chk(dn, 8'h00);
		acc(1'b1, ADDR_STAT, 8'hff);
		chk(dn, 8'h01);
		acc(1'b0, ADDR_STAT, 8'h00);
		chk(rd, ID_CHIP_TYPE);
		status_in = 8'h96;
		acc(1'b0, ADDR_STAT_LV, 8'h00);
		chk(rd, 8'h96);
		status_in = 8'h69;
		acc(1'b0, ADDR_STAT_LV, 8'h00);
		chk(rd, 8'h69);
		lock_regs = 1'b0;
		$display("test read only done");
	endtask : t_ro
	// a write offered while the clock enable is low must not land
	task automatic t_freeze;
		clk_en = 1'b0;
		acc(1'b1, ADDR_CFG_LO, 8'ha5);
		clk_en = 1'b1;
		acc(1'b0, ADDR_CFG_LO, 8'h00);
		chk(rd, 8'h5a);
		$display("test freeze done");
	endtask : t_freeze
	// ==========================================================
	// main sequence and watchdog
	initial begin
		arst_n = 1'b0;
		clk_en = 1'b1;
		src_serial = 1'b0;
		lock_regs = 1'b0;
		action_done = 1'b0;
		status_in = 8'h00;
		repeat (10) @(posedge mclk);
		#1 arst_n = 1'b1;
		t_buffer();
		t_freeze();
		t_live();
		t_deny();
		t_ro();
		close_out();
	end
	initial begin
		#20000;
		n_mismatch++;
		close_out();
	end
endmodule : register_access_policy_tb_top
